//--- src/rdd_ref_divider.sv
// Reference divider: 2 MHz to 1 MHz antiphase, then divide by two or by three
//
// What this block does
// - Halve 2 MHz reference into antiphase 1 MHz
// - Divide-by-two: second stage gives 500 kHz output
// - Divide-by-two: third stage and reset gate idle
// - Divide-by-three: half-microsecond reset clears second stage
// - Third stage toggles on second stage fall
// - Divide-by-three output high 2 us, low 1 us
// - Output gates second stage with third stage
// - Stages change only on a falling reference edge
`timescale 1ns/1ps
module rdd_ref_divider
	import rdd_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic ce_i,
	input  wire logic ref_i,
	input  wire logic div3_sel_i,
	output logic      half_ref_o,
	output logic      half_ref_n_o,
	output logic      div_out_o,
	output rdd_mode_t mode_o
);

	// ****************************************************************
	// Reference edge detection
	// ****************************************************************
	logic       ref_prev;
	logic       step;
	rdd_stage_t stage;
	rdd_stage_t next_stage;
	logic       mode_meta;
	rdd_mode_t  next_mode;
	logic       rst_pulse;
	logic       second_fall;
	logic       next_out;

	// Ref is synchronous to clk, so one flop suffices for edge detection
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ref_prev <= REF_PREV_RST;
		end else if (ce_i) begin
			ref_prev <= ref_i;
		end
	end

	assign step = ce_i & ref_prev & ~ref_i;

	// ****************************************************************
	// Mode synchroniser
	// ****************************************************************
	// Two stages clocked by the reference edge; mode is a static level, so a
	// change may cost one odd output period but never a torn stage state
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			mode_meta <= 1'b0;
			mode_o    <= RDD_DIV2;
		end else if (step) begin
			mode_meta <= div3_sel_i;
			mode_o    <= next_mode;
		end
	end

	assign next_mode = rdd_mode_t'(mode_meta);

	// ****************************************************************
	// Divider stages
	// ****************************************************************
	// First stage toggles every reference fall
	rdd_toggle_stage u_first_toggle_stage (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.step_i   (step),
		.tog_i    (1'b1),
		.clr_i    (1'b0),
		.q_o      (stage.first),
		.next_q_o (next_stage.first)
	);

	// Antiphase copy kept as its own flop so both phases come from registers
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			half_ref_n_o <= ~STAGE_RST;
		end else if (step) begin
			half_ref_n_o <= ~next_stage.first;
		end
	end

	assign half_ref_o = stage.first;

	// Reset gate pair: low phase of 1 MHz gated by third stage, only in div3
	assign rst_pulse = (next_mode == RDD_DIV3) & stage.third & ~next_stage.first;

	// Second stage toggles when the inverted 1 MHz falls, i.e. first stage rises
	rdd_toggle_stage u_second_toggle_stage (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.step_i   (step),
		.tog_i    (~stage.first),
		.clr_i    (rst_pulse),
		.q_o      (stage.second),
		.next_q_o (next_stage.second)
	);

	assign second_fall = stage.second & ~next_stage.second;

	// Third stage held cleared in div2 so its level stays constant
	rdd_toggle_stage u_third_toggle_stage (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.step_i   (step),
		.tog_i    (second_fall),
		.clr_i    (next_mode == RDD_DIV2),
		.q_o      (stage.third),
		.next_q_o (next_stage.third)
	);

	// ****************************************************************
	// Output gate pair
	// ****************************************************************
	// In div2 the third term is zero, so output is the 500 kHz second stage inverted
	assign next_out = next_stage.third | ~next_stage.second;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			div_out_o <= ~STAGE_RST;
		end else if (step) begin
			div_out_o <= next_out;
		end
	end

	// ****************************************************************
	// Checking helpers
	// ****************************************************************
	logic [2:0] seg_cnt;
	logic [3:0] steady_cnt;

	// Periods spent at the current output level, counting the changing one
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			seg_cnt <= 3'h1;
		end else if (step) begin
			if (next_out != div_out_o) begin
				seg_cnt <= 3'h1;
			end else if (seg_cnt != 3'h7) begin
				seg_cnt <= seg_cnt + 3'h1;
			end
		end
	end

	// Periods since the synchronised mode last changed, saturating
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			steady_cnt <= 4'h0;
		end else if (step) begin
			if (next_mode != mode_o) begin
				steady_cnt <= 4'h0;
			end else if (steady_cnt != MODE_STEADY_SLOT) begin
				steady_cnt <= steady_cnt + 4'h1;
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_step;
		step;
	endsequence

	sequence s_div3_steady;
		mode_o == RDD_DIV3 && steady_cnt == MODE_STEADY_SLOT;
	endsequence

	a_phase_anti: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		half_ref_n_o == ~half_ref_o)
		else $error("1 MHz phases not complementary");

	a_first_toggles: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_step |=> half_ref_o != $past(half_ref_o))
		else $error("first stage missed a reference fall");

	a_idle_stable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!step |=> $stable(stage) && $stable(div_out_o))
		else $error("stage changed without a reference fall");

	a_div2_square: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_step ##0 (next_mode == RDD_DIV2 && !half_ref_o))
		|=> (stage.second != $past(stage.second)) && (div_out_o == ~stage.second))
		else $error("div2 second stage failed to toggle");

	a_div2_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		mode_o == RDD_DIV2 |-> !stage.third && !rst_pulse)
		else $error("third stage or reset gate active in div2");

	a_reset_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_step ##0 rst_pulse) |=> !stage.second ##1 (!step)[*1])
		else $error("reset pulse did not clear second stage");

	a_third_on_fall: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_step ##0 (next_mode == RDD_DIV3 && second_fall))
		|=> stage.third != $past(stage.third))
		else $error("third stage missed second stage fall");

	a_out_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		div_out_o == (stage.third | ~stage.second))
		else $error("output gate mismatch");

	a_div3_high_len: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_step ##0 s_div3_steady ##0 (div_out_o && !next_out))
		|-> seg_cnt == DIV3_HIGH_SLOTS)
		else $error("div3 high time wrong");

	a_div3_low_len: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_step ##0 s_div3_steady ##0 (!div_out_o && next_out))
		|-> seg_cnt == DIV3_LOW_SLOTS)
		else $error("div3 low time wrong");

	a_mode_sync: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_step |=> mode_o == rdd_mode_t'($past(mode_meta)))
		else $error("mode not taken through synchroniser");

endmodule

//--- src/rdd_pkg.sv
// Shared constants and types for the reference divide-by-two / divide-by-three divider
package rdd_pkg;

	// ****************************************************************
	// Clock and reference timing
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_NS  = 50;         // System clock, 20 MHz
	localparam int unsigned REF_HZ         = 2_000_000;  // Crystal reference rate
	localparam int unsigned SLOT_NS        = 1_000_000_000 / REF_HZ;  // One reference period
	localparam int unsigned SLOT_CYC       = SLOT_NS / CLK_PERIOD_NS; // Clocks per reference period
	localparam int unsigned DIV3_HIGH_NS   = 2000;       // Divide-by-three high time
	localparam int unsigned DIV3_LOW_NS    = 1000;       // Divide-by-three low time
	localparam int unsigned RESET_PULSE_NS = 500;        // Reset gate pulse width

	// Times above expressed in reference periods (the block steps once per period)
	localparam logic [2:0] DIV3_HIGH_SLOTS  = 3'(DIV3_HIGH_NS / SLOT_NS);
	localparam logic [2:0] DIV3_LOW_SLOTS   = 3'(DIV3_LOW_NS / SLOT_NS);
	localparam logic [2:0] RESET_SLOTS      = 3'(RESET_PULSE_NS / SLOT_NS);
	localparam logic [3:0] MODE_STEADY_SLOT = 4'h8;      // Settling allowance after a mode change

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic STAGE_RST    = 1'b0;
	localparam logic REF_PREV_RST = 1'b0;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic {
		RDD_DIV2 = 1'b0,
		RDD_DIV3 = 1'b1
	} rdd_mode_t;

	typedef struct packed {
		logic third;
		logic second;
		logic first;
	} rdd_stage_t;

endpackage

//--- src/rdd_toggle_stage.sv
// One binary toggle stage with synchronous clear, stepped once per reference period
`timescale 1ns/1ps
module rdd_toggle_stage
	import rdd_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic step_i,
	input  wire logic tog_i,
	input  wire logic clr_i,
	output logic      q_o,
	output logic      next_q_o
);

	// Clear dominates toggle, as a reset input would on the flip-flop
	always_comb begin
		if (clr_i) begin
			next_q_o = 1'b0;
		end else if (tog_i) begin
			next_q_o = ~q_o;
		end else begin
			next_q_o = q_o;
		end
	end

	// State moves only on a step, which is one reference falling edge
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			q_o <= STAGE_RST;
		end else if (step_i) begin
			q_o <= next_q_o;
		end
	end

endmodule

//--- verification/rdd_far_side.sv
// Far-side model: channel control line and first downstream divider stage
`timescale 1ns/1ps
module rdd_far_side (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic [7:0] chan_i,
	input  wire logic       div_i,
	output logic            div3_sel_o,
	output logic [7:0]      falls_o
);
	logic prev;

	// Control line is a static level chosen by channel number
	assign div3_sel_o = (chan_i >= 8'hB4);

	// Downstream binary reacts only to falling edges, so count those
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			prev    <= 1'b1;
			falls_o <= 8'h00;
		end else begin
			prev <= div_i;
			if (prev && !div_i) begin
				falls_o <= falls_o + 8'h01;
			end
		end
	end
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the reference divider
`timescale 1ns/1ps
module tb_top
	import rdd_pkg::*;
;
	logic       clk     = 1'b0;
	logic       rst_b   = 1'b0;
	logic       ce      = 1'b1;
	logic       ref_clk = 1'b0;
	logic [7:0] chan    = 8'hB3;
	logic [7:0] falls;
	logic [7:0] f0;
	logic       div3_sel;
	logic       half_ref;
	logic       half_ref_n;
	logic       div_out;
	rdd_mode_t  mode;
	int         err_total   = 0;
	int         checks_done = 0;
	int         hi;
	int         lo;

	// 20 MHz system clock
	always #25 clk = ~clk;

	rdd_ref_divider dut (.clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .ref_i(ref_clk),
		.div3_sel_i(div3_sel), .half_ref_o(half_ref), .half_ref_n_o(half_ref_n),
		.div_out_o(div_out), .mode_o(mode));
	rdd_far_side far (.clk_i(clk), .rst_b_i(rst_b), .chan_i(chan), .div_i(div_out),
		.div3_sel_o(div3_sel), .falls_o(falls));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// One reference period, five clocks high then five low; outputs settle before return
	task automatic slot(input logic tog);
		logic was;
		was = half_ref;
		for (int i = 0; i < int'(SLOT_CYC); i++) begin
			@(negedge clk);
			ref_clk = (i < int'(SLOT_CYC / 2));
		end
		check("half_ref", {7'h00, half_ref}, {7'h00, was ^ tog});
		check("half_ref_n", {7'h00, half_ref_n}, {7'h00, ~half_ref});
	endtask

	// Length in slots of the current output level, bounded so a stuck output ends
	task automatic run_len(input logic lvl, output int n);
		n = 0;
		while (div_out === lvl && n < 12) begin
			slot(1'b1);
			n++;
		end
	endtask

	task automatic measure();
		run_len(1'b1, hi);
		run_len(1'b0, lo);
		run_len(1'b1, hi);
		run_len(1'b0, lo);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic test_div2();
		chan = 8'hB3;
		repeat (3) slot(1'b1);
		measure();
		check("div2 high", 8'(hi), 8'h02);
		check("div2 low", 8'(lo), 8'h02);
		check("div2 mode", 8'(mode), 8'(RDD_DIV2));
	endtask

	task automatic test_div3();
		chan = 8'hB4;
		repeat (4) slot(1'b1);
		measure();
		check("div3 high", 8'(hi), 8'(DIV3_HIGH_SLOTS));
		check("div3 low", 8'(lo), 8'(DIV3_LOW_SLOTS));
		check("div3 mode", 8'(mode), 8'(RDD_DIV3));
		f0 = falls;
		repeat (6) slot(1'b1);
		check("falls per 3us", 8'(falls - f0), 8'h01);
	endtask

	// Clock enable low: reference edges are ignored and nothing moves
	task automatic test_freeze();
		logic d;
		d = div_out;
		ce = 1'b0;
		repeat (3) slot(1'b0);
		check("frozen out", {7'h00, div_out}, {7'h00, d});
		ce = 1'b1;
	endtask

	// Reset in mid-run with the upper channel still selected
	task automatic test_reset_mode();
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		check("mode after reset", 8'(mode), 8'(RDD_DIV2));
		slot(1'b1);
		check("mode one slot", 8'(mode), 8'(RDD_DIV2));
		slot(1'b1);
		check("mode two slots", 8'(mode), 8'(RDD_DIV3));
	endtask

	// ****************************************************************
	// Run control
	// ****************************************************************
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence; reset is held across two clocks
	initial begin
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		test_div2();
		test_div3();
		test_freeze();
		test_reset_mode();
		test_div2();
		print_verdict();
	end

	// Watchdog: the sequence needs well under 2000 clocks
	initial begin
		#400_000;
		err_total++;
		print_verdict();
	end
endmodule
